// ==== logic/port_mgmt.sv ====
// Port control, port status, PHY register views and statistics counters.
// Functional notes
// - LED-off bit 15 drives all four port LEDs high; else normal.
// - Bit 14 disables the port transmitter.
// - Writing one to bit 13 restarts auto-negotiation.
// - Bits 10 and 9 together force crossed mode.
// - Bit 7 enables auto-negotiation; off means bits 6 and 5 decide.
// - Bit 6 forces 100 Mbps, zero forces 10 Mbps, without negotiation.
// - Bit 5 forces full duplex when negotiation is off or fails.
// - Bits 4 to 0 choose the advertised abilities.
// - Control bits other than bit 10 alias the PHY control and advertisement views.
// - Writable status bit 15 picks the crossover algorithm, resets to one.
// - Status bits 10 and 9 show resolved speed and duplex.
// - Status bits 6 and 5 show negotiation done and link good.
// - Status bits 4 to 0 show partner abilities.
// - Thirty-two 32-bit counters clear when read.
// - Counters are read indirectly at offsets 0x00 to 0x1F.
// - Offset 0x0 counts received octets, 0x15 good transmitted octets.
// - Offsets 0x2 to 0x5 count undersize, fragment, oversize, jabber.
// - Bad CRC frames of 64 to 2000 octets split by whole bytes.
// - Offset 0x9 counts control frames, 0xA qualified pause frames.
// - Offsets 0xB to 0xD count good broadcast, multicast, unicast.
// - Offsets 0xE to 0x14 bin received frames by length.
// - Offset 0x16 counts late collisions, 0x17 sent pause frames.
// - Offsets 0x18 to 0x1F count transmit and collision events.
`timescale 1ns/10ps
module port_mgmt #(
   parameter int NCNT = 32,
   parameter int CW = 32
) (
   input wire logic CORE_CLK,
   input wire logic RSTN,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_WDATA,
   output logic [15:0] REG_RDATA,
   input wire port_mgmt_pkg::phy_stat_s PHY_STAT,
   input wire logic [3:0] LED_IND,
   input wire logic RX_DONE,
   input wire port_mgmt_pkg::rx_frame_s RX_FRAME,
   input wire logic TX_DONE,
   input wire port_mgmt_pkg::tx_frame_s TX_FRAME,
   output logic [3:0] PORT_LED_OUT,
   output logic TX_DISABLE,
   output logic AN_ENABLE,
   output logic AN_RESTART,
   output logic FORCE_100,
   output logic FORCE_FULL,
   output logic [4:0] ADV_ABIL,
   output logic AUTO_MDIX_OFF,
   output logic FORCE_MDIX,
   output logic XOVER_ALG
);
   logic [15:0] ctrl_reg;
   logic xalg_reg;
   logic restart_reg;
   logic [15:0] pstat;
   logic [15:0] bctl_view;
   logic [15:0] bsts_view;
   logic [15:0] adv_view;
   logic [15:0] lpa_view;
   logic [15:0] rdata_next;
   logic wr_pctl;
   logic wr_bctl;
   logic wr_adv;
   logic cnt_rd;
   logic [$clog2(NCNT)-1:0] cnt_idx;
   logic [CW-1:0] cnt_data;
   logic [NCNT-1:0][port_mgmt_pkg::ADD_W-1:0] cnt_add;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes.

   assign wr_pctl = REG_WR && REG_ADDR == port_mgmt_pkg::PCTL_ADR;
   assign wr_bctl = REG_WR && REG_ADDR == port_mgmt_pkg::BCTL_ADR;
   assign wr_adv = REG_WR && REG_ADDR == port_mgmt_pkg::ADV_ADR;

   // Both PHY views write straight into the port control bits they share.
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctrl_reg <= port_mgmt_pkg::PCTL_RST;
      end else if (wr_pctl) begin
         ctrl_reg <= REG_WDATA & port_mgmt_pkg::PCTL_WMASK;
      end else if (wr_bctl) begin
         ctrl_reg[port_mgmt_pkg::C_LEDOFF] <= REG_WDATA[port_mgmt_pkg::B_LEDOFF];
         ctrl_reg[port_mgmt_pkg::C_TXDIS] <= REG_WDATA[port_mgmt_pkg::B_TXDIS];
         ctrl_reg[port_mgmt_pkg::C_FMDIX] <= REG_WDATA[port_mgmt_pkg::B_FMDIX];
         ctrl_reg[port_mgmt_pkg::C_ANEN] <= REG_WDATA[port_mgmt_pkg::B_ANEN];
         ctrl_reg[port_mgmt_pkg::C_SPD] <= REG_WDATA[port_mgmt_pkg::B_SPD];
         ctrl_reg[port_mgmt_pkg::C_DPX] <= REG_WDATA[port_mgmt_pkg::B_DPX];
      end else if (wr_adv) begin
         ctrl_reg[4] <= REG_WDATA[port_mgmt_pkg::V_PAUSE];
         ctrl_reg[3:0] <= REG_WDATA[port_mgmt_pkg::V_ABIL +: 4];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         xalg_reg <= port_mgmt_pkg::XALG_RST;
      end else if (REG_WR && REG_ADDR == port_mgmt_pkg::PSTS_ADR) begin
         xalg_reg <= REG_WDATA[port_mgmt_pkg::S_XALG];
      end else if (wr_bctl) begin
         xalg_reg <= REG_WDATA[port_mgmt_pkg::B_XALG];
      end
   end

   // Restart is a one-shot: it is never stored, so it always reads as zero.
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         restart_reg <= 1'b0;
      end else begin
         restart_reg <= (wr_pctl && REG_WDATA[port_mgmt_pkg::C_RESTART])
            || (wr_bctl && REG_WDATA[port_mgmt_pkg::B_RESTART]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line-side outputs.

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PORT_LED_OUT <= 4'hf;
      end else begin
         PORT_LED_OUT <= ctrl_reg[port_mgmt_pkg::C_LEDOFF] ? 4'hf : LED_IND;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         TX_DISABLE <= 1'b0;
         AN_ENABLE <= 1'b1;
         AN_RESTART <= 1'b0;
         FORCE_100 <= 1'b1;
         FORCE_FULL <= 1'b1;
         ADV_ABIL <= 5'h1f;
         AUTO_MDIX_OFF <= 1'b0;
         FORCE_MDIX <= 1'b0;
         XOVER_ALG <= port_mgmt_pkg::XALG_RST;
      end else begin
         TX_DISABLE <= ctrl_reg[port_mgmt_pkg::C_TXDIS];
         AN_ENABLE <= ctrl_reg[port_mgmt_pkg::C_ANEN];
         AN_RESTART <= restart_reg;
         FORCE_100 <= ctrl_reg[port_mgmt_pkg::C_SPD];
         FORCE_FULL <= ctrl_reg[port_mgmt_pkg::C_DPX];
         ADV_ABIL <= ctrl_reg[4:0];
         AUTO_MDIX_OFF <= ctrl_reg[port_mgmt_pkg::C_NOMDIX];
         FORCE_MDIX <= ctrl_reg[port_mgmt_pkg::C_NOMDIX]
            && ctrl_reg[port_mgmt_pkg::C_FMDIX];
         XOVER_ALG <= xalg_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register views and reads.

   always_comb begin
      pstat = '0;
      pstat[port_mgmt_pkg::S_XALG] = xalg_reg;
      pstat[port_mgmt_pkg::S_POL] = PHY_STAT.pol_rev;
      pstat[port_mgmt_pkg::S_SPD] = PHY_STAT.spd100;
      pstat[port_mgmt_pkg::S_DPX] = PHY_STAT.full;
      pstat[port_mgmt_pkg::S_MDI] = PHY_STAT.mdi;
      pstat[port_mgmt_pkg::S_AND] = PHY_STAT.an_done;
      pstat[port_mgmt_pkg::S_LNK] = PHY_STAT.link;
      pstat[4:0] = PHY_STAT.partner;
   end

   always_comb begin
      bctl_view = '0;
      bctl_view[port_mgmt_pkg::B_LEDOFF] = ctrl_reg[port_mgmt_pkg::C_LEDOFF];
      bctl_view[port_mgmt_pkg::B_TXDIS] = ctrl_reg[port_mgmt_pkg::C_TXDIS];
      bctl_view[port_mgmt_pkg::B_FMDIX] = ctrl_reg[port_mgmt_pkg::C_FMDIX];
      bctl_view[port_mgmt_pkg::B_XALG] = xalg_reg;
      bctl_view[port_mgmt_pkg::B_DPX] = ctrl_reg[port_mgmt_pkg::C_DPX];
      bctl_view[port_mgmt_pkg::B_ANEN] = ctrl_reg[port_mgmt_pkg::C_ANEN];
      bctl_view[port_mgmt_pkg::B_SPD] = ctrl_reg[port_mgmt_pkg::C_SPD];
      bsts_view = '0;
      bsts_view[port_mgmt_pkg::V_AND] = PHY_STAT.an_done;
      bsts_view[port_mgmt_pkg::V_LNK] = PHY_STAT.link;
      adv_view = '0;
      adv_view[port_mgmt_pkg::V_PAUSE] = ctrl_reg[4];
      adv_view[port_mgmt_pkg::V_ABIL +: 4] = ctrl_reg[3:0];
      adv_view[4:0] = port_mgmt_pkg::V_SELECTOR;
      lpa_view = '0;
      lpa_view[port_mgmt_pkg::V_PAUSE] = PHY_STAT.partner[4];
      lpa_view[port_mgmt_pkg::V_ABIL +: 4] = PHY_STAT.partner[3:0];
      lpa_view[4:0] = port_mgmt_pkg::V_SELECTOR;
   end

   always_comb begin
      unique case (REG_ADDR)
         port_mgmt_pkg::PCTL_ADR: rdata_next = ctrl_reg;
         port_mgmt_pkg::PSTS_ADR: rdata_next = pstat;
         port_mgmt_pkg::BCTL_ADR: rdata_next = bctl_view;
         port_mgmt_pkg::BSTS_ADR: rdata_next = bsts_view;
         port_mgmt_pkg::ADV_ADR: rdata_next = adv_view;
         port_mgmt_pkg::LPA_ADR: rdata_next = lpa_view;
         port_mgmt_pkg::IND_HI_ADR: rdata_next = cnt_data[31:16];
         port_mgmt_pkg::IND_LO_ADR: rdata_next = cnt_data[15:0];
         default: rdata_next = 16'h0000;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         REG_RDATA <= 16'h0000;
      end else if (REG_RD) begin
         REG_RDATA <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Statistics counters.

   assign cnt_rd = REG_WR && REG_ADDR == port_mgmt_pkg::IND_CTRL_ADR
      && REG_WDATA[port_mgmt_pkg::IA_RD]
      && REG_WDATA[port_mgmt_pkg::IA_SEL +: 2] == port_mgmt_pkg::IA_SEL_MIB;
   assign cnt_idx = REG_WDATA[$clog2(NCNT)-1:0];

   frame_event_map #(.N(NCNT)) u_map (
      .rx_v(RX_DONE),
      .rx(RX_FRAME),
      .tx_v(TX_DONE),
      .tx(TX_FRAME),
      .half_dpx(!PHY_STAT.full),
      .add(cnt_add)
   );

   stat_counter_bank #(.N(NCNT), .W(CW)) u_bank (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .add(cnt_add),
      .rd_req(cnt_rd),
      .rd_idx(cnt_idx),
      .rd_data(cnt_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_LED_OFF: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      wr_pctl && REG_WDATA[15] |=> ##1 PORT_LED_OUT == 4'hf)
      else $error("LEDs not forced high");
   AST_TX_DIS: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      wr_pctl |=> ##1 TX_DISABLE == $past(REG_WDATA[14], 2))
      else $error("transmitter disable not applied");
   AST_RESTART: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      wr_pctl && REG_WDATA[13] |=> ##1 AN_RESTART ##1 !AN_RESTART)
      else $error("restart pulse wrong");
   AST_MDIX: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      FORCE_MDIX |-> $past(ctrl_reg[10]) && $past(ctrl_reg[9]))
      else $error("crossed mode forced without both bits");
   AST_ALIAS: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      wr_bctl |=> ctrl_reg[7] == $past(REG_WDATA[12]) && ctrl_reg[6] == $past(REG_WDATA[13]))
      else $error("PHY control view write not seen in port control");
   AST_SPEED: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      REG_RD && REG_ADDR == 8'hf8 |=> REG_RDATA[10] == $past(PHY_STAT.spd100))
      else $error("status speed bit wrong");
   AST_LINK: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      REG_RD && REG_ADDR == 8'he6 |=> REG_RDATA[2] == $past(PHY_STAT.link))
      else $error("basic status link bit wrong");
   AST_UNMAPPED: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == 16'h0000)
      else $error("unmapped read not zero");
   AST_ADV: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      wr_pctl |=> ##1 ADV_ABIL == $past(REG_WDATA[4:0], 2))
      else $error("advertised abilities not applied");
endmodule : port_mgmt

// ==== logic/port_mgmt_pkg.sv ====
// Shared constants and carriers for the port management block.
package port_mgmt_pkg;
   // Byte addresses of the host-visible registers.
   localparam logic [7:0] IND_CTRL_ADR = 8'hc8;
   localparam logic [7:0] IND_HI_ADR = 8'hd0;
   localparam logic [7:0] IND_LO_ADR = 8'hd2;
   localparam logic [7:0] BCTL_ADR = 8'he4;
   localparam logic [7:0] BSTS_ADR = 8'he6;
   localparam logic [7:0] ADV_ADR = 8'hec;
   localparam logic [7:0] LPA_ADR = 8'hee;
   localparam logic [7:0] PCTL_ADR = 8'hf6;
   localparam logic [7:0] PSTS_ADR = 8'hf8;
   // Port control fields.
   localparam int C_LEDOFF = 15, C_TXDIS = 14, C_RESTART = 13, C_NOMDIX = 10;
   localparam int C_FMDIX = 9, C_ANEN = 7, C_SPD = 6, C_DPX = 5;
   localparam logic [15:0] PCTL_RST = 16'h00ff;
   localparam logic [15:0] PCTL_WMASK = 16'hc6ff;
   // Port status fields.
   localparam int S_XALG = 15, S_POL = 13, S_SPD = 10, S_DPX = 9, S_MDI = 7;
   localparam int S_AND = 6, S_LNK = 5;
   localparam logic XALG_RST = 1'b1;
   // Alias positions in the standard PHY views.
   localparam int B_LEDOFF = 0, B_TXDIS = 1, B_FMDIX = 4, B_XALG = 5, B_DPX = 8;
   localparam int B_RESTART = 9, B_ANEN = 12, B_SPD = 13;
   localparam int V_AND = 5, V_LNK = 2, V_PAUSE = 10, V_ABIL = 5;
   localparam logic [4:0] V_SELECTOR = 5'h01;
   // Indirect access control fields.
   localparam int IA_RD = 12, IA_SEL = 10;
   localparam logic [1:0] IA_SEL_MIB = 2'h3;
   // Frame length limits in octets.
   localparam logic [10:0] LEN_MIN = 11'd64, LEN_OVR = 11'd1536, LEN_MAX = 11'd2000;
   localparam logic [10:0] LEN_B1 = 11'd127, LEN_B2 = 11'd255, LEN_B3 = 11'd511;
   localparam logic [10:0] LEN_B4 = 11'd1023, LEN_B5 = 11'd1521;
   localparam int ADD_W = 11;
   // Counter offsets.
   localparam int M_RXOCT = 0, M_UNDER = 2, M_FRAG = 3, M_OVER = 4, M_JAB = 5;
   localparam int M_SYM = 6, M_CRC = 7, M_ALIGN = 8, M_CTL = 9, M_PAUSE = 10;
   localparam int M_BC = 11, M_MC = 12, M_UC = 13, M_B64 = 14, M_B127 = 15;
   localparam int M_B255 = 16, M_B511 = 17, M_B1023 = 18, M_B1521 = 19;
   localparam int M_B2000 = 20, M_TXOCT = 21, M_LATE = 22, M_TXPAUSE = 23;
   localparam int M_TXBC = 24, M_TXMC = 25, M_TXUC = 26, M_DEFER = 27;
   localparam int M_COLL = 28, M_EXCESS = 29, M_SINGLE = 30, M_MULTI = 31;

   typedef struct packed {
      logic link;
      logic an_done;
      logic spd100;
      logic full;
      logic mdi;
      logic pol_rev;
      logic [4:0] partner;
   } phy_stat_s;

   typedef struct packed {
      logic [10:0] len;
      logic crc_ok;
      logic whole;
      logic sym_err;
      logic bcast;
      logic mcast;
      logic type8808;
      logic pause_fmt;
   } rx_frame_s;

   typedef struct packed {
      logic [10:0] len;
      logic good;
      logic bcast;
      logic mcast;
      logic pause;
      logic deferred;
      logic late;
      logic excess;
      logic [3:0] coll;
   } tx_frame_s;
endpackage : port_mgmt_pkg

// ==== logic/frame_event_map.sv ====
// Maps one finished frame onto the amounts added to each statistics counter.
`timescale 1ns/10ps
module frame_event_map #(
   parameter int N = 32
) (
   input wire logic rx_v,
   input wire port_mgmt_pkg::rx_frame_s rx,
   input wire logic tx_v,
   input wire port_mgmt_pkg::tx_frame_s tx,
   input wire logic half_dpx,
   output logic [N-1:0][port_mgmt_pkg::ADD_W-1:0] add
);
   logic rx_good;
   logic [10:0] l;

   assign l = rx.len;
   assign rx_good = rx.crc_ok && !rx.sym_err && l >= port_mgmt_pkg::LEN_MIN
      && l <= port_mgmt_pkg::LEN_MAX;

   always_comb begin
      add = '0;
      if (rx_v) begin
         add[port_mgmt_pkg::M_RXOCT] = l;
         add[port_mgmt_pkg::M_UNDER] = 11'(l < port_mgmt_pkg::LEN_MIN && rx.crc_ok);
         add[port_mgmt_pkg::M_FRAG] = 11'(l < port_mgmt_pkg::LEN_MIN && !rx.crc_ok);
         add[port_mgmt_pkg::M_OVER] = 11'(l > port_mgmt_pkg::LEN_OVR && rx.crc_ok);
         add[port_mgmt_pkg::M_JAB] = 11'(l > port_mgmt_pkg::LEN_OVR
            && (!rx.crc_ok || rx.sym_err));
         add[port_mgmt_pkg::M_SYM] = 11'(rx.sym_err && l >= port_mgmt_pkg::LEN_MIN
            && l <= port_mgmt_pkg::LEN_OVR);
         add[port_mgmt_pkg::M_CRC] = 11'(!rx.crc_ok && rx.whole
            && l >= port_mgmt_pkg::LEN_MIN && l <= port_mgmt_pkg::LEN_MAX);
         add[port_mgmt_pkg::M_ALIGN] = 11'(!rx.crc_ok && !rx.whole
            && l >= port_mgmt_pkg::LEN_MIN && l <= port_mgmt_pkg::LEN_MAX);
         add[port_mgmt_pkg::M_CTL] = 11'(rx.type8808);
         add[port_mgmt_pkg::M_PAUSE] = 11'(rx.type8808 && rx.pause_fmt && rx.crc_ok
            && l >= port_mgmt_pkg::LEN_MIN);
         add[port_mgmt_pkg::M_BC] = 11'(rx_good && rx.bcast);
         add[port_mgmt_pkg::M_MC] = 11'(rx_good && rx.mcast && !rx.bcast && !rx.type8808);
         add[port_mgmt_pkg::M_UC] = 11'(rx_good && !rx.mcast && !rx.bcast);
         add[port_mgmt_pkg::M_B64] = 11'(l == port_mgmt_pkg::LEN_MIN);
         add[port_mgmt_pkg::M_B127] = 11'(l > port_mgmt_pkg::LEN_MIN && l <= port_mgmt_pkg::LEN_B1);
         add[port_mgmt_pkg::M_B255] = 11'(l > port_mgmt_pkg::LEN_B1 && l <= port_mgmt_pkg::LEN_B2);
         add[port_mgmt_pkg::M_B511] = 11'(l > port_mgmt_pkg::LEN_B2 && l <= port_mgmt_pkg::LEN_B3);
         add[port_mgmt_pkg::M_B1023] = 11'(l > port_mgmt_pkg::LEN_B3 && l <= port_mgmt_pkg::LEN_B4);
         add[port_mgmt_pkg::M_B1521] = 11'(l > port_mgmt_pkg::LEN_B4 && l <= port_mgmt_pkg::LEN_B5);
         add[port_mgmt_pkg::M_B2000] = 11'(l > port_mgmt_pkg::LEN_B5
            && l <= port_mgmt_pkg::LEN_MAX);
      end
      if (tx_v) begin
         add[port_mgmt_pkg::M_TXOCT] = tx.good ? tx.len : 11'h000;
         add[port_mgmt_pkg::M_LATE] = 11'(tx.late);
         add[port_mgmt_pkg::M_TXPAUSE] = 11'(tx.pause);
         add[port_mgmt_pkg::M_TXBC] = 11'(tx.good && tx.bcast);
         add[port_mgmt_pkg::M_TXMC] = 11'(tx.good && tx.mcast && !tx.bcast);
         add[port_mgmt_pkg::M_TXUC] = 11'(tx.good && !tx.mcast && !tx.bcast);
         add[port_mgmt_pkg::M_DEFER] = 11'(tx.deferred);
         add[port_mgmt_pkg::M_COLL] = half_dpx ? 11'(tx.coll) : 11'h000;
         add[port_mgmt_pkg::M_EXCESS] = 11'(tx.excess);
         add[port_mgmt_pkg::M_SINGLE] = 11'(tx.good && tx.coll == 4'h1);
         add[port_mgmt_pkg::M_MULTI] = 11'(tx.good && tx.coll > 4'h1);
      end
   end
endmodule : frame_event_map

// ==== logic/stat_counter_bank.sv ====
// Bank of read-clear statistics counters with one read port.
`timescale 1ns/10ps
module stat_counter_bank #(
   parameter int N = 32,
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [N-1:0][port_mgmt_pkg::ADD_W-1:0] add,
   input wire logic rd_req,
   input wire logic [$clog2(N)-1:0] rd_idx,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] cnt [N];

   // A counter read in the same cycle as an event restarts at that event.
   for (genvar i = 0; i < N; i++) begin : g_cnt
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            cnt[i] <= '0;
         end else if (rd_req && rd_idx == i) begin
            cnt[i] <= W'(add[i]);
         end else begin
            cnt[i] <= cnt[i] + W'(add[i]);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= '0;
      end else if (rd_req) begin
         rd_data <= cnt[rd_idx];
      end
   end

   AST_RD_SELECT: assert property (@(posedge clk) disable iff (!rstn)
      rd_req |=> rd_data == $past(cnt[rd_idx]))
      else $error("counter read returned the wrong entry");
   AST_RD_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
      rd_req |=> cnt[$past(rd_idx)] == W'($past(add[rd_idx])))
      else $error("counter not cleared by its read");
endmodule : stat_counter_bank

// ==== tb/host_model.sv ====
// Host processor model that drives the register strobe bus.
`timescale 1ns/10ps
module host_model (
   input wire logic clk,
   output logic [7:0] addr,
   output logic wr,
   output logic rd,
   output logic [15:0] wdata,
   input wire logic [15:0] rdata
);
   initial begin
      addr = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 16'h0000;
   end
   // Released address and data are inverted so a stale value cannot pass for a live one.
   task automatic write(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : write
   task automatic read(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      @(negedge clk);
      d = rdata;
   endtask : read
   // Trigger with the offset, then take the upper word before the lower word.
   task automatic read_counter(input int off, output logic [31:0] v);
      logic [15:0] hi;
      logic [15:0] lo;
      write(port_mgmt_pkg::IND_CTRL_ADR, 16'h1c00 | 16'(off[4:0]));
      read(port_mgmt_pkg::IND_HI_ADR, hi);
      read(port_mgmt_pkg::IND_LO_ADR, lo);
      v = {hi, lo};
   endtask : read_counter
endmodule : host_model

// ==== tb/testbench.sv ====
// Self-checking bench for the port management block with a counter model.
`timescale 1ns/10ps
module testbench;
   logic core_clk;
   logic rstn;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   port_mgmt_pkg::phy_stat_s phy_stat;
   logic [3:0] led_ind;
   logic rx_done;
   port_mgmt_pkg::rx_frame_s rx_frame;
   logic tx_done;
   port_mgmt_pkg::tx_frame_s tx_frame;
   logic [3:0] led_out;
   logic tx_dis;
   logic an_en;
   logic an_rst;
   logic f100;
   logic ffull;
   logic [4:0] adv;
   logic mdix_off;
   logic fmdix;
   logic xalg;
   int seed = 5;
   int err_count = 0;
   int comparisons = 0;
   longint cnt [33];
   int lens [8] = '{64, 127, 128, 1521, 1522, 1536, 1537, 2000};
   localparam logic [31:0] MODELED = 32'hffffffff;

   port_mgmt i_dut (.CORE_CLK(core_clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .PHY_STAT(phy_stat),
      .LED_IND(led_ind), .RX_DONE(rx_done), .RX_FRAME(rx_frame), .TX_DONE(tx_done),
      .TX_FRAME(tx_frame), .PORT_LED_OUT(led_out), .TX_DISABLE(tx_dis), .AN_ENABLE(an_en),
      .AN_RESTART(an_rst), .FORCE_100(f100), .FORCE_FULL(ffull), .ADV_ABIL(adv),
      .AUTO_MDIX_OFF(mdix_off), .FORCE_MDIX(fmdix), .XOVER_ALG(xalg));
   host_model i_host (.clk(core_clk), .addr(reg_addr), .wr(reg_wr), .rd(reg_rd),
      .wdata(reg_wdata), .rdata(reg_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      err_count++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   task automatic chk_ctl(input logic [15:0] v);
      check({17'h0, led_out, tx_dis, an_en, f100, ffull, adv, mdix_off, fmdix},
         {17'h0, v[15] ? 4'hf : led_ind, v[14], v[7], v[6], v[5], v[4:0], v[10], v[10] & v[9]});
   endtask : chk_ctl
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] mask, input logic [15:0] exp);
      logic [15:0] d;
      i_host.read(a, d);
      check({16'h0, d & mask}, {16'h0, exp});
   endtask : rd_chk

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] v;
      logic [31:0] c;
      int r;
      int k;
      port_mgmt_pkg::rx_frame_s f;
      port_mgmt_pkg::tx_frame_s t;
      port_mgmt_pkg::phy_stat_s p;
      rstn = 1'b0;
      phy_stat = '0;
      led_ind = 4'($random(seed));
      rx_done = 1'b0;
      rx_frame = '0;
      tx_done = 1'b0;
      tx_frame = '0;
      foreach (cnt[i]) cnt[i] = 0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      // The release edge itself still sees reset, so let one live edge load the outputs.
      @(posedge core_clk);
      @(negedge core_clk);
      chk_ctl(16'h00ff);
      check({31'h0, xalg}, 32'h1);
      rd_chk(port_mgmt_pkg::PCTL_ADR, 16'hffff, 16'h00ff);
      rd_chk(port_mgmt_pkg::PSTS_ADR, 16'hffff, 16'h8000);
      rd_chk(8'h00, 16'hffff, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         v = 16'($random(seed)) & 16'hdfff;
         i_host.write(port_mgmt_pkg::PCTL_ADR, v);
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         chk_ctl(v);
         rd_chk(port_mgmt_pkg::PCTL_ADR, 16'hffff, v & 16'hc6ff);
         rd_chk(port_mgmt_pkg::BCTL_ADR, 16'h3133, {2'h0, v[6], v[7], 3'h0, v[5], 2'h0, 1'b1,
            v[9], 2'h0, v[14], v[15]});
         rd_chk(port_mgmt_pkg::ADV_ADR, 16'h05ff, {5'h0, v[4], 1'b0, v[3:0], 5'h01});
      end
      i_host.write(port_mgmt_pkg::BCTL_ADR, 16'h0000);
      rd_chk(port_mgmt_pkg::PCTL_ADR, 16'hffff, v & 16'h041f);
      check({31'h0, xalg}, 32'h0);
      i_host.write(port_mgmt_pkg::PCTL_ADR, 16'h20ff);
      k = 0;
      repeat (6) begin
         @(negedge core_clk);
         if (an_rst === 1'b1) k++;
      end
      check(32'(k), 32'h1);
      rd_chk(port_mgmt_pkg::PCTL_ADR, 16'hffff, 16'h00ff);
      $display("test control done");
      for (int i = 0; i < 4; i++) begin
         p = 11'($random(seed));
         @(posedge core_clk);
         phy_stat <= p;
         i_host.write(port_mgmt_pkg::PSTS_ADR, {i[0], 15'h7fff});
         repeat (2) @(posedge core_clk);
         @(negedge core_clk);
         check({31'h0, xalg}, {31'h0, i[0]});
         rd_chk(port_mgmt_pkg::PSTS_ADR, 16'hffff, {i[0], 1'b0, p.pol_rev, 2'h0, p.spd100,
            p.full, 1'b0, p.mdi, p.an_done, p.link, p.partner});
         rd_chk(port_mgmt_pkg::BSTS_ADR, 16'h0024, {10'h0, p.an_done, 2'h0, p.link, 2'h0});
         rd_chk(port_mgmt_pkg::LPA_ADR, 16'h05ff, {5'h0, p.partner[4], 1'b0, p.partner[3:0],
            5'h01});
      end
      $display("test status done");
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         f = '0;
         f.len = (i < 8) ? 11'(lens[i]) : 11'(64 + (r & 32'hffff) % 1937);
         f.crc_ok = r[16] | r[17];
         f.whole = r[18];
         f.bcast = r[19];
         f.mcast = r[20] & ~r[19];
         f.type8808 = r[21] & f.mcast;
         f.pause_fmt = r[22];
         t = '0;
         t.len = 11'(64 + (r & 32'h3ff));
         t.good = 1'b1;
         t.pause = r[24];
         t.late = r[25];
         t.bcast = r[26];
         t.mcast = r[27] & ~r[26];
         @(posedge core_clk);
         rx_frame <= f;
         tx_frame <= t;
         rx_done <= 1'b1;
         tx_done <= 1'b1;
         @(posedge core_clk);
         rx_done <= 1'b0;
         tx_done <= 1'b0;
         cnt[0] += f.len;
         k = f.len == 64 ? 14 : f.len <= 127 ? 15 : f.len <= 255 ? 16 : f.len <= 511 ? 17 :
            f.len <= 1023 ? 18 : f.len <= 1521 ? 19 : 20;
         cnt[k]++;
         if (!f.crc_ok) cnt[f.whole ? 7 : 8]++;
         if (f.len > 1536) cnt[f.crc_ok ? 4 : 5]++;
         cnt[9] += f.type8808;
         cnt[10] += f.type8808 & f.pause_fmt & f.crc_ok;
         if (f.crc_ok) cnt[f.bcast ? 11 : f.mcast ? (f.type8808 ? 32 : 12) : 13]++;
         cnt[21] += t.len;
         cnt[22] += t.late;
         cnt[23] += t.pause;
         cnt[t.bcast ? 24 : t.mcast ? 25 : 26]++;
      end
      for (int q = 0; q < 2; q++) begin
         for (int o = 0; o < 32; o++) begin
            i_host.read_counter(o, c);
            if (q == 1 || MODELED[o]) check(c, q == 1 ? 32'h0 : 32'(cnt[o]));
         end
      end
      $display("test counters done");
      stop_test();
   end
endmodule : testbench
